// ---- design/rcar_pkg.sv ----
package rcar_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [13:0] CFG_IDX      = 14'h0f3f;
  localparam logic [13:0] VAL_HIGH_IDX = 14'h0f30;
  localparam logic [13:0] VAL_LOW_IDX  = 14'h0f31;
  localparam logic [13:0] ALM_SET_IDX  = 14'h0f32;
  localparam logic [13:0] ALM_RPT_IDX  = 14'h0f33;
  localparam logic [13:0] PAD_SET_IDX  = 14'h0f34;
  localparam logic [13:0] IRQ_STA_IDX  = 14'h0f35;
  localparam logic [13:0] IRQ_MSK_IDX  = 14'h0f36;

  // ==========================================================
  // field positions
  localparam int CFG_TON_BIT    = 7;
  localparam int CFG_UNLOCK_BIT = 5;
  localparam int CFG_ROLL_BIT   = 4;
  localparam int CFG_HALF_BIT   = 3;
  localparam int CFG_OE_BIT     = 2;
  localparam int ALM_ON_BIT     = 7;
  localparam int ALM_ENDLESS_BIT = 6;
  localparam int PAD_LPRUN_BIT  = 2;

  // ==========================================================
  // reset values and codes
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [7:0] ALM_SET_RST = 8'h00;
  localparam logic [7:0] ALM_RPT_RST = 8'h00;
  localparam logic [7:0] PAD_SET_RST = 8'h00;
  localparam logic [7:0] RPT_MAX     = 8'hff;
  localparam logic [3:0] ALM_SINGLE  = 4'h0;
  localparam logic [1:0] SRC_PULSE   = 2'h0;
  localparam logic [1:0] SRC_SECONDS = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] SEC_WRAP    = 8'h3b;

  // ==========================================================
  // timing
  localparam longint SECOND_NS      = 1000000000;
  localparam longint MCLK_PERIOD_NS = 4;
  localparam int     TICKS_PER_SEC  = int'(SECOND_NS / MCLK_PERIOD_NS);
  localparam int     ROLL_WINDOW    = 32;
  localparam int     PRESC_W        = 28;

  // ==========================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } rcar_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcar_axi_rsp_s;

endpackage

// ---- design/rcar_sync.sv ----
`timescale 1ns/1ps
module rcar_sync
  import rcar_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // level in and out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1Reg;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1Reg <= 1'b0;
      syncOut   <= 1'b0;
    end
    else
    begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule

// ---- design/rcar_top.sv ----
// Summary of operation
// R1 - timekeeper_on only writable while value_write_unlock is one
// R2 - second_half_flag read-only, zeroed by write of seconds byte
// R3 - config register reset by power-on reset only
// R4 - setup field zero and endless clear gives a single alarm
// R5 - eight-bit repeat count, ff gives 255 extra alarms
// R6 - each alarm decrements count; at zero one last alarm occurs
// R7 - after the last non-endless alarm alarm_on clears itself
// R8 - endless repeat keeps alarm on, count wraps zero to ff
// R9 - every alarm event sets the interrupt flag; irq is raised only while the mask is one
// R10 - alarm pulse toggles per alarm, half rate, 50% duty
// R11 - pin_source_select 00 picks alarm pulse, else seconds clock
// R12 - optional running in low power; alarm wakes the processor
// R13 - device reset clears alarm setup and repeat count
// R14 - device reset does not stop a running timekeeper
// R15 - prescaler cleared only by writing seconds, never by reset
// R16 - value pointer picks pair, decrements per high-byte access, stops at zero
// R17 - rollover_pending set near a carry so software reads twice
// R18 - pin_output_on gates the selected source onto the pin
`timescale 1ns/1ps
module rcar_top
  import rcar_pkg::*;
#(
  parameter int unsigned ticksPerSec = TICKS_PER_SEC
)
(
  // clock and power-on reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // device reset pin
  input  wire logic          devRst_n,
  // register bus
  input  wire rcar_axi_req_s axiReq,
  output rcar_axi_rsp_s      axiRsp,
  // alarm match and power state
  input  wire logic          alarmMatch,
  input  wire logic          lowPower,
  // outputs
  output logic               irq,
  output logic               wakeReq,
  output logic               rtcPin,
  output logic               rtcPinOe
);

  // ==========================================================
  // device reset synchroniser
  logic devRstSync_n;

  rcar_sync uDevRst (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn (devRst_n),
    .syncOut (devRstSync_n)
  );

  logic devReset;
  assign devReset = !devRstSync_n;

  // ==========================================================
  // bus slave state
  logic        awGotReg;
  logic        wGotReg;
  logic [13:0] wrIdxReg;
  logic [31:0] wrDataReg;
  logic        wrStrbReg;
  logic        awreadyReg;
  logic        wreadyReg;
  logic        bvalidReg;
  logic [1:0]  brespReg;
  logic        arreadyReg;
  logic        rvalidReg;
  logic [31:0] rdataReg;
  logic [1:0]  rrespReg;

  logic        wrFire;
  logic        rdFire;
  logic [13:0] rdIdx;
  logic        wrByte;
  logic [7:0]  wrVal;

  assign wrFire = awGotReg && wGotReg && !bvalidReg;
  assign rdFire = axiReq.arvalid && arreadyReg;
  assign rdIdx  = axiReq.araddr[15:2];
  assign wrByte = wrFire && wrStrbReg;
  assign wrVal  = wrDataReg[7:0];

  // ==========================================================
  // block state
  logic        tonReg;
  logic        unlockReg;
  logic        oeReg;
  logic [1:0]  ptrReg;
  logic [7:0]  almSetReg;
  logic [7:0]  rptReg;
  logic [7:0]  padSetReg;
  logic        irqStaReg;
  logic        irqMskReg;
  logic        pulseReg;
  logic [15:0] valReg [4];
  logic [PRESC_W-1:0] prescReg;

  logic [PRESC_W-1:0] prescLast;
  logic [PRESC_W-1:0] prescHalf;
  logic [PRESC_W-1:0] prescRoll;
  logic        run;
  logic        tick;
  logic        second_half_flag;
  logic        rollover;
  logic        alarmEvt;
  logic        secWrite;
  logic        valWrHigh;
  logic        valWrLow;
  logic        valRdHigh;

  assign prescLast = PRESC_W'(ticksPerSec - 1);
  assign prescHalf = PRESC_W'(ticksPerSec / 2);
  assign prescRoll = PRESC_W'(ticksPerSec - 1 - ROLL_WINDOW);

  // R12 low power run
  assign run = tonReg && (!lowPower || padSetReg[PAD_LPRUN_BIT]);
  assign tick = run && (prescReg == prescLast);
  // R2 flag follows prescaler
  assign second_half_flag = prescReg >= prescHalf;
  // R17 carry window
  assign rollover = tonReg && (prescReg >= prescRoll);
  assign alarmEvt = alarmMatch && almSetReg[ALM_ON_BIT];

  assign valWrHigh = wrByte && unlockReg && (wrIdxReg == VAL_HIGH_IDX);
  assign valWrLow  = wrByte && unlockReg && (wrIdxReg == VAL_LOW_IDX);
  assign valRdHigh = rdFire && (rdIdx == VAL_HIGH_IDX);
  assign secWrite  = valWrLow && (ptrReg == 2'h0);

  // ==========================================================
  // write channels
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awGotReg   <= 1'b0;
      wGotReg    <= 1'b0;
      wrIdxReg   <= 14'h0000;
      wrDataReg  <= 32'h0000_0000;
      wrStrbReg  <= 1'b0;
      awreadyReg <= 1'b0;
      wreadyReg  <= 1'b0;
      bvalidReg  <= 1'b0;
      brespReg   <= RESP_OKAY;
    end
    else
    begin
      if (axiReq.awvalid && awreadyReg)
      begin
        awGotReg   <= 1'b1;
        awreadyReg <= 1'b0;
        wrIdxReg   <= axiReq.awaddr[15:2];
      end
      else if (!awGotReg && !bvalidReg)
      begin
        awreadyReg <= 1'b1;
      end
      if (axiReq.wvalid && wreadyReg)
      begin
        wGotReg   <= 1'b1;
        wreadyReg <= 1'b0;
        wrDataReg <= axiReq.wdata;
        wrStrbReg <= axiReq.wstrb[0];
      end
      else if (!wGotReg && !bvalidReg)
      begin
        wreadyReg <= 1'b1;
      end
      if (wrFire)
      begin
        awGotReg  <= 1'b0;
        wGotReg   <= 1'b0;
        bvalidReg <= 1'b1;
        brespReg  <= ((wrIdxReg >= VAL_HIGH_IDX && wrIdxReg <= IRQ_MSK_IDX)
                      || wrIdxReg == CFG_IDX) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalidReg && axiReq.bready)
      begin
        bvalidReg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arreadyReg <= 1'b0;
      rvalidReg  <= 1'b0;
      rdataReg   <= 32'h0000_0000;
      rrespReg   <= RESP_OKAY;
    end
    else if (rdFire)
    begin
      arreadyReg <= 1'b0;
      rvalidReg  <= 1'b1;
      rrespReg   <= RESP_OKAY;
      unique case (rdIdx)
        CFG_IDX:
          rdataReg <= {24'h000000, tonReg, 1'b0, unlockReg, rollover, second_half_flag,
                       oeReg, ptrReg};
        VAL_HIGH_IDX: rdataReg <= {24'h000000, valReg[ptrReg][15:8]};
        VAL_LOW_IDX:  rdataReg <= {24'h000000, valReg[ptrReg][7:0]};
        ALM_SET_IDX:  rdataReg <= {24'h000000, almSetReg};
        ALM_RPT_IDX:  rdataReg <= {24'h000000, rptReg};
        PAD_SET_IDX:  rdataReg <= {24'h000000, padSetReg};
        IRQ_STA_IDX:  rdataReg <= {31'h00000000, irqStaReg};
        IRQ_MSK_IDX:  rdataReg <= {31'h00000000, irqMskReg};
        default:
        begin
          rdataReg <= 32'h0000_0000;
          rrespReg <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalidReg && axiReq.rready)
    begin
      rvalidReg  <= 1'b0;
      arreadyReg <= 1'b1;
    end
    else if (!rvalidReg)
    begin
      arreadyReg <= 1'b1;
    end
  end

  // ==========================================================
  // configuration, power-on reset only
  // R3 no device reset here
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tonReg    <= CFG_RST[CFG_TON_BIT];
      unlockReg <= CFG_RST[CFG_UNLOCK_BIT];
      oeReg     <= CFG_RST[CFG_OE_BIT];
      padSetReg <= PAD_SET_RST;
    end
    else if (wrByte && wrIdxReg == CFG_IDX)
    begin
      // R1 guarded by current unlock
      if (unlockReg)
      begin
        tonReg <= wrVal[CFG_TON_BIT];
      end
      unlockReg <= wrVal[CFG_UNLOCK_BIT];
      oeReg     <= wrVal[CFG_OE_BIT];
    end
    else if (wrByte && wrIdxReg == PAD_SET_IDX)
    begin
      padSetReg <= wrVal;
    end
  end

  // ==========================================================
  // value pointer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptrReg <= CFG_RST[1:0];
    end
    else if (wrByte && wrIdxReg == CFG_IDX)
    begin
      ptrReg <= wrVal[1:0];
    end
    // R16 step down after high access
    else if ((valRdHigh || valWrHigh) && ptrReg != 2'h0)
    begin
      ptrReg <= ptrReg - 2'h1;
    end
  end

  // ==========================================================
  // prescaler: never reset, so a seconds write must precede use
  // R15 cleared by seconds write only
  always_ff @(posedge mclk)
  begin
    if (secWrite)
    begin
      prescReg <= '0;
    end
    else if (run)
    begin
      prescReg <= tick ? '0 : prescReg + PRESC_W'(1);
    end
  end

  // ==========================================================
  // value pairs; only minutes and seconds count here
  // R14 counting ignores device reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        valReg[i] <= 16'h0000;
      end
    end
    else if (valWrHigh)
    begin
      valReg[ptrReg][15:8] <= wrVal;
    end
    else if (valWrLow)
    begin
      valReg[ptrReg][7:0] <= wrVal;
    end
    else if (tick)
    begin
      if (valReg[0][7:0] >= SEC_WRAP)
      begin
        valReg[0][7:0]  <= 8'h00;
        valReg[0][15:8] <= (valReg[0][15:8] >= SEC_WRAP) ? 8'h00
                           : valReg[0][15:8] + 8'h01;
      end
      else
      begin
        valReg[0][7:0] <= valReg[0][7:0] + 8'h01;
      end
    end
  end

  // ==========================================================
  // alarm setup and repeat count
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      almSetReg <= ALM_SET_RST;
      rptReg    <= ALM_RPT_RST;
    end
    // R13 device reset disarms
    else if (devReset)
    begin
      almSetReg <= ALM_SET_RST;
      rptReg    <= ALM_RPT_RST;
    end
    else
    begin
      if (wrByte && wrIdxReg == ALM_SET_IDX)
      begin
        almSetReg <= wrVal;
      end
      // R5 full eight-bit load
      if (wrByte && wrIdxReg == ALM_RPT_IDX)
      begin
        rptReg <= wrVal;
      end
      if (alarmEvt)
      begin
        // R4 single alarm mode
        if (almSetReg[5:2] == ALM_SINGLE && !almSetReg[ALM_ENDLESS_BIT])
        begin
          almSetReg[ALM_ON_BIT] <= 1'b0;
        end
        else if (rptReg != 8'h00)
        begin
          // R6 count down
          rptReg <= rptReg - 8'h01;
        end
        else if (almSetReg[ALM_ENDLESS_BIT])
        begin
          // R8 wrap and continue
          rptReg <= RPT_MAX;
        end
        else
        begin
          // R7 last alarm switches off
          almSetReg[ALM_ON_BIT] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // interrupt status and mask, set wins over clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqStaReg <= 1'b0;
      irqMskReg <= 1'b0;
      irq       <= 1'b0;
    end
    else
    begin
      // R9 flag every alarm
      if (alarmEvt)
      begin
        irqStaReg <= 1'b1;
      end
      else if (wrByte && wrIdxReg == IRQ_STA_IDX && wrVal[0])
      begin
        irqStaReg <= 1'b0;
      end
      if (wrByte && wrIdxReg == IRQ_MSK_IDX)
      begin
        irqMskReg <= wrVal[0];
      end
      irq <= irqStaReg && irqMskReg;
    end
  end

  // ==========================================================
  // alarm pulse, wake and pin
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulseReg <= 1'b0;
      wakeReq  <= 1'b0;
      rtcPin   <= 1'b0;
      rtcPinOe <= 1'b0;
    end
    else
    begin
      // R10 toggle per alarm
      if (alarmEvt)
      begin
        pulseReg <= !pulseReg;
      end
      // R12 wake on alarm
      wakeReq <= alarmEvt && lowPower;
      // R18 gate onto pin
      rtcPinOe <= oeReg;
      // R11 source select
      if (!oeReg)
      begin
        rtcPin <= 1'b0;
      end
      else if (padSetReg[1:0] == SRC_PULSE)
      begin
        rtcPin <= pulseReg;
      end
      else
      begin
        rtcPin <= second_half_flag;
      end
    end
  end

  assign axiRsp.awready = awreadyReg;
  assign axiRsp.wready  = wreadyReg;
  assign axiRsp.bvalid  = bvalidReg;
  assign axiRsp.bresp   = brespReg;
  assign axiRsp.arready = arreadyReg;
  assign axiRsp.rvalid  = rvalidReg;
  assign axiRsp.rdata   = rdataReg;
  assign axiRsp.rresp   = rrespReg;

endmodule

// ---- tb/rcar_top_asserts.sv ----
`timescale 1ns/1ps
module rcar_top_asserts
  import rcar_pkg::*;
(
  // clock and power-on reset
  input wire logic          mclk,
  input wire logic          rst_n,
  // register bus
  input wire rcar_axi_req_s axiReq,
  input wire rcar_axi_rsp_s axiRsp,
  // alarm side
  input wire logic          alarmMatch,
  input wire logic          lowPower,
  input wire logic          wakeReq,
  input wire logic          rtcPin,
  input wire logic          rtcPinOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // bus and pin relations
  property p_bHold;
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped early");
  property p_bLat;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |-> ##2 axiRsp.bvalid;
  endproperty
  a_bLat: assert property (p_bLat) else $error("write response late");
  property p_rHold;
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data dropped early");
  property p_rLat;
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid;
  endproperty
  a_rLat: assert property (p_rLat) else $error("read data late");
  property p_arBlock;
    axiRsp.rvalid |-> !axiRsp.arready;
  endproperty
  a_arBlock: assert property (p_arBlock) else $error("second read accepted");
  property p_upper;
    axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_pinOff;
    !rtcPinOe |-> !rtcPin;
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("pin driven while off");
  property p_wake;
    wakeReq |-> $past(alarmMatch) && $past(lowPower);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without alarm");
endmodule

bind rcar_top rcar_top_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .axiReq(axiReq),
  .axiRsp(axiRsp), .alarmMatch(alarmMatch), .lowPower(lowPower), .wakeReq(wakeReq),
  .rtcPin(rtcPin), .rtcPinOe(rtcPinOe));

// ---- tb/rtc_config_alarm_repeat_tb.sv ----
`timescale 1ns/1ps
module rtc_config_alarm_repeat_tb;
  import rcar_pkg::*;
  // short second keeps the prescaler scenarios quick
  localparam int TPS = 200;
  logic          mclk, rst_n, devRst_n, alarmMatch, lowPower;
  logic          irq, wakeReq, rtcPin, rtcPinOe, b;
  rcar_axi_req_s axiReq;
  rcar_axi_rsp_s axiRsp;
  int            failures = 0, samplesChecked = 0, cyc = 0, wakes = 0, ev = 0, n;
  logic [31:0]   rd;
  logic [1:0]    rsp;
  logic [7:0]    cnt, base;
  logic [7:0]    vals [4];

  rcar_top #(.ticksPerSec(TPS)) dut (.mclk(mclk), .rst_n(rst_n), .devRst_n(devRst_n),
    .axiReq(axiReq), .axiRsp(axiRsp), .alarmMatch(alarmMatch), .lowPower(lowPower),
    .irq(irq), .wakeReq(wakeReq), .rtcPin(rtcPin), .rtcPinOe(rtcPinOe));

  always #2 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc++;
    if (wakeReq === 1'b1) wakes++;
    if (cyc == 60000)
    begin
      failures++;
      finishTest();
    end
  end

  // ==========================================================
  // helpers
  task automatic finishTest;
    if (failures == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    @(posedge mclk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= {16'h0000, i, 2'b00};
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= {24'h000000, d};
    axiReq.wstrb   <= 4'hf;
    do
    begin
      @(posedge mclk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    // late bready makes the slave hold its response for a cycle
    axiReq.bready <= 1'b1;
    @(posedge mclk);
    axiReq.bready <= 1'b0;
    chk({30'h0, axiRsp.bresp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rdr(input logic [13:0] i);
    @(posedge mclk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= {16'h0000, i, 2'b00};
    do
    begin
      @(posedge mclk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1);
    // late rready makes the slave hold its read data for a cycle
    axiReq.rready <= 1'b1;
    @(posedge mclk);
    axiReq.rready <= 1'b0;
    rd = axiRsp.rdata;
    rsp = axiRsp.rresp;
  endtask

  task automatic rc(input logic [13:0] i, input logic [7:0] m, input logic [7:0] e);
    rdr(i);
    chk(rd & {24'h0, m}, {24'h0, e});
  endtask

  // polls until a masked bit is set, bounded
  task automatic poll(input logic [13:0] i, input logic [7:0] m);
    n = 0;
    do
    begin
      rdr(i);
      n++;
    end while ((rd[7:0] & m) == 8'h00 && n < 200);
    chk({31'h0, n < 200}, 32'h1);
  endtask

  task automatic fire(input logic lp);
    @(posedge mclk);
    alarmMatch <= 1'b1;
    lowPower   <= lp;
    @(posedge mclk);
    alarmMatch <= 1'b0;
    lowPower   <= 1'b0;
  endtask

  task automatic edges;
    n = 0;
    // sample between edges so a value launched at the last edge is settled
    @(negedge mclk);
    b = rtcPin;
    repeat (3 * TPS)
    begin
      @(negedge mclk);
      if (rtcPin !== b) n++;
      b = rtcPin;
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    devRst_n = 1'b1;
    alarmMatch = 1'b0;
    lowPower = 1'b0;
    axiReq = '0;
    void'($urandom(32'h66e20388));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // prescaler is unknown until seconds are written, so bit 3 is masked
    rc(CFG_IDX, 8'hf7, CFG_RST);
    rc(ALM_SET_IDX, 8'hff, ALM_SET_RST);
    rc(ALM_RPT_IDX, 8'hff, ALM_RPT_RST);
    rdr(14'h0100);
    chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(CFG_IDX, 8'h80);
    rc(CFG_IDX, 8'hf7, 8'h00);
    wr(CFG_IDX, 8'h20);
    wr(VAL_LOW_IDX, 8'h00);
    wr(CFG_IDX, 8'ha4);
    rc(CFG_IDX, 8'he7, 8'ha4);
    poll(CFG_IDX, 8'h08);
    wr(VAL_LOW_IDX, 8'h00);
    rc(CFG_IDX, 8'h08, 8'h00);
    poll(CFG_IDX, 8'h10);
    wr(CFG_IDX, 8'h84);
    wr(CFG_IDX, 8'h04);
    rc(CFG_IDX, 8'he7, 8'h84);
    wr(CFG_IDX, 8'ha7);
    for (int p = 3; p > 0; p--)
    begin
      vals[p] = 8'($urandom);
      wr(VAL_HIGH_IDX, vals[p]);
    end
    rc(CFG_IDX, 8'h03, 8'h00);
    wr(CFG_IDX, 8'ha7);
    for (int p = 3; p > 0; p--) rc(VAL_HIGH_IDX, 8'hff, vals[p]);
    rc(CFG_IDX, 8'h03, 8'h00);
    wr(ALM_SET_IDX, 8'h84);
    wr(ALM_RPT_IDX, 8'h05);
    devRst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    devRst_n <= 1'b1;
    rc(ALM_SET_IDX, 8'hff, 8'h00);
    rc(ALM_RPT_IDX, 8'hff, 8'h00);
    rc(CFG_IDX, 8'he7, 8'ha4);
    // alarm sequences, pulse source, pin on
    wr(IRQ_MSK_IDX, 8'h01);
    wr(PAD_SET_IDX, 8'h04);
    base = {7'h0, rtcPin};
    for (int k = 0; k < 2; k++)
    begin
      cnt = k ? RPT_MAX : 8'($urandom_range(6, 1));
      wr(ALM_RPT_IDX, cnt);
      wr(ALM_SET_IDX, 8'h84);
      repeat (cnt) fire(1'b0);
      rc(ALM_RPT_IDX, 8'hff, 8'h00);
      rc(ALM_SET_IDX, 8'hff, 8'h84);
      fire(1'b1);
      rc(ALM_SET_IDX, 8'hff, 8'h04);
      fire(1'b0);
      ev += cnt + 1;
    end
    chk(wakes, 2);
    wr(ALM_RPT_IDX, 8'h03);
    wr(ALM_SET_IDX, 8'h80);
    fire(1'b0);
    rc(ALM_SET_IDX, 8'hff, 8'h00);
    wr(ALM_RPT_IDX, 8'h01);
    wr(ALM_SET_IDX, 8'hc4);
    fire(1'b0);
    fire(1'b0);
    ev += 3;
    rc(ALM_RPT_IDX, 8'hff, 8'hff);
    rc(ALM_SET_IDX, 8'hff, 8'hc4);
    chk({31'h0, rtcPin}, {31'h0, base[0] ^ ev[0]});
    chk({31'h0, irq}, 32'h1);
    wr(IRQ_MSK_IDX, 8'h00);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(IRQ_STA_IDX, 8'h01);
    wr(IRQ_MSK_IDX, 8'h01);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    fire(1'b0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rc(IRQ_STA_IDX, 8'h01, 8'h01);
    chk({31'h0, rtcPin}, {31'h0, base[0] ^ ~ev[0]});
    // seconds clock on the pin, then pin off
    wr(PAD_SET_IDX, {6'h01, SRC_SECONDS});
    edges();
    chk({31'h0, n >= 4}, 32'h1);
    wr(CFG_IDX, 8'ha0);
    edges();
    chk({rtcPinOe, n[30:0]}, 32'h0);
    finishTest();
  end
endmodule
